// ==== hw/smpr_map.vh ====
// How it works
// R1: Direct window at 0x0C000000 goes to SRAM
// R2: Extended window from 0x80000000, DDR or SRAM
// R3: After reset extended window maps to DDR
// R4: Extension registers redirect extended segments to SRAM
// R5: SRAM and DDR paths run independently
// R6: Every write returns status, streams merged; unmapped writes only set decode_err_ff, no status
// R7: SRAM responses win over DDR responses
// R8: Full DDR response queue stalls, never drops
// R9: Coherence source 0x52 waits for write status
// R10: Masters avoid extended aliases of SRAM
// R11: Each response carries requester source id
`ifndef SMPR_MAP_VH
`define SMPR_MAP_VH
`define SMPR_DIRECT_BASE 32'h0C00_0000
`define SMPR_DIRECT_MASK 32'hFF00_0000
`define SMPR_EXT_BASE 32'h8000_0000
`define SMPR_EXT_MASK 32'h8000_0000
`define SMPR_COH_SID 8'h52
`define SMPR_SEG_LSB 27
`define SMPR_SEG_W 4
`define SMPR_SRAM_OFS_MASK 32'h00FF_FFFF
`define SMPR_MAP_RST 16'h0000
`endif

// ==== hw/smpr_resp_fifo.v ====
`timescale 1ns/1ps
module smpr_resp_fifo #(
   parameter W = 10,
   parameter DEPTH_LOG2 = 2
) (
   input wire clock,
   input wire rst_n,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output reg [W-1:0] out_data
);
   localparam DEPTH = 1 << DEPTH_LOG2;
   reg [W-1:0] mem [0:DEPTH-1];
   reg [DEPTH_LOG2:0] wp_ff;
   reg [DEPTH_LOG2:0] rp_ff;
   reg full_q;
   reg have_ff;
   wire empty_mem;
   wire push;
   wire pop_mem;
   assign empty_mem = (wp_ff == rp_ff);
   always @*
   begin
      full_q = (wp_ff[DEPTH_LOG2] != rp_ff[DEPTH_LOG2]) &&
         (wp_ff[DEPTH_LOG2-1:0] == rp_ff[DEPTH_LOG2-1:0]);
   end
   assign in_ready = ~full_q;
   assign push = in_valid & ~full_q;
   assign out_valid = have_ff;
   // Refill the registered output stage when it empties or is taken
   assign pop_mem = ~empty_mem & (~have_ff | out_ready);
   always @(posedge clock)
   begin
      if (push)
      begin
         mem[wp_ff[DEPTH_LOG2-1:0]] <= in_data;
      end
      if (pop_mem)
      begin
         out_data <= mem[rp_ff[DEPTH_LOG2-1:0]];
      end
   end
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         wp_ff <= {(DEPTH_LOG2+1){1'b0}};
         rp_ff <= {(DEPTH_LOG2+1){1'b0}};
         have_ff <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wp_ff <= wp_ff + 1'b1;
         end
         if (pop_mem)
         begin
            rp_ff <= rp_ff + 1'b1;
            have_ff <= 1'b1;
         end
         else if (out_ready)
         begin
            have_ff <= 1'b0;
         end
      end
   end
endmodule

// ==== hw/smpr_router.v ====
`timescale 1ns/1ps
`include "smpr_map.vh"
module smpr_router #(
   parameter SID_W = 8,
   parameter DDR_Q_LOG2 = 2
) (
   input wire clock,
   input wire rst_n,
   input wire req_valid,
   output wire req_ready,
   input wire [31:0] req_addr,
   input wire req_write,
   input wire [SID_W-1:0] req_sid,
   input wire [15:0] ext_sram_map,
   output wire sram_req_valid,
   input wire sram_req_ready,
   output wire [31:0] sram_req_addr,
   output wire sram_req_write,
   output wire [SID_W-1:0] sram_req_sid,
   output wire sram_req_ext,
   input wire sram_rsp_valid,
   output wire sram_rsp_ready,
   input wire sram_rsp_write,
   input wire [SID_W-1:0] sram_rsp_sid,
   input wire sram_rsp_ext,
   output wire ddr_req_valid,
   input wire ddr_req_ready,
   output wire [31:0] ddr_req_addr,
   output wire ddr_req_write,
   output wire [SID_W-1:0] ddr_req_sid,
   input wire ddr_rsp_valid,
   output wire ddr_rsp_ready,
   input wire ddr_rsp_write,
   input wire [SID_W-1:0] ddr_rsp_sid,
   output reg rsp_valid_ff,
   input wire rsp_ready,
   output reg rsp_write_ff,
   output reg [SID_W-1:0] rsp_sid_ff,
   output reg rsp_from_ddr_ff,
   output reg decode_err_ff,
   output reg coh_wait_ff
);
   // Output slot owner: which path filled the response register
   localparam ST_IDLE = 3'b001;
   localparam ST_SRAM = 3'b010;
   localparam ST_DDR = 3'b100;
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [15:0] map_ff;
   wire hit_direct;
   wire hit_ext;
   wire ext_to_sram;
   wire ddr_q_valid;
   wire ddr_q_ready;
   wire ddr_q_write;
   wire [SID_W-1:0] ddr_q_sid;
   wire take_sram;
   wire take_ddr;
   wire out_free;
   wire coh_issue;
   wire coh_done;
   localparam COH_CNT_W = 8;
   reg [COH_CNT_W-1:0] coh_cnt_ff;
   reg [COH_CNT_W-1:0] nxt_coh_cnt;

   // Direct window is a fixed 16 MB slice of shared SRAM
   function in_direct;
      input [31:0] addr;
      begin
         in_direct = ((addr & `SMPR_DIRECT_MASK) == `SMPR_DIRECT_BASE);
      end
   endfunction

   function in_ext;
      input [31:0] addr;
      begin
         in_ext = ((addr & `SMPR_EXT_MASK) == `SMPR_EXT_BASE);
      end
   endfunction

   function [31:0] rebase_sram;
      input [31:0] addr;
      begin
         rebase_sram = (addr & `SMPR_SRAM_OFS_MASK) | `SMPR_DIRECT_BASE;
      end
   endfunction

   function seg_sram;
      input [31:0] addr;
      input [15:0] map;
      begin
         seg_sram = map[addr[`SMPR_SEG_LSB+`SMPR_SEG_W-1:`SMPR_SEG_LSB]];
      end
   endfunction

   assign hit_direct = in_direct(req_addr); // R1
   assign hit_ext = in_ext(req_addr); // R2
   // Map resets to all-DDR; a set bit sends that 128 MB segment to SRAM
   assign ext_to_sram = hit_ext & seg_sram(req_addr, map_ff); // R3 R4

   // Separate request paths to each memory
   assign sram_req_valid = req_valid & (hit_direct | ext_to_sram); // R1 R5
   assign sram_req_addr = hit_direct ? req_addr : rebase_sram(req_addr); // R4
   assign sram_req_write = req_write;
   assign sram_req_sid = req_sid; // R11
   assign sram_req_ext = ext_to_sram;
   assign ddr_req_valid = req_valid & hit_ext & ~ext_to_sram; // R3 R5
   assign ddr_req_addr = req_addr;
   assign ddr_req_write = req_write;
   assign ddr_req_sid = req_sid; // R11
   // Unmapped requests are accepted and flagged
   assign req_ready = hit_direct | ext_to_sram ? sram_req_ready :
      (hit_ext ? ddr_req_ready : 1'b1);

   // DDR responses buffered; full queue holds off the DDR side
   smpr_resp_fifo #(
      .W(SID_W + 1),
      .DEPTH_LOG2(DDR_Q_LOG2)
   ) u_ddr_q (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(ddr_rsp_valid),
      .in_ready(ddr_rsp_ready), // R8
      .in_data({ddr_rsp_write, ddr_rsp_sid}),
      .out_valid(ddr_q_valid),
      .out_ready(ddr_q_ready),
      .out_data({ddr_q_write, ddr_q_sid})
   );

   // Output slot is free when empty or being taken this cycle
   assign out_free = ~rsp_valid_ff | rsp_ready;
   always @*
   begin
      nxt_state = ST_IDLE;
      case (state_ff)
         ST_IDLE, ST_SRAM, ST_DDR:
         begin
            if (!out_free)
            begin
               nxt_state = state_ff;
            end
            else if (sram_rsp_valid)
            begin
               nxt_state = ST_SRAM; // R7
            end
            else if (ddr_q_valid)
            begin
               nxt_state = ST_DDR;
            end
         end
         default:
         begin
            nxt_state = ST_IDLE;
         end
      endcase
   end
   assign take_sram = out_free & (nxt_state == ST_SRAM); // R7
   assign take_ddr = out_free & (nxt_state == ST_DDR); // R7 R8
   assign sram_rsp_ready = out_free;
   assign ddr_q_ready = take_ddr;

   // Only decoded writes ever get a completion, so only they are counted
   assign coh_issue = req_valid & req_ready & req_write &
      (hit_direct | hit_ext) & (req_sid == `SMPR_COH_SID);
   assign coh_done = rsp_valid_ff & rsp_ready & rsp_write_ff &
      (rsp_sid_ff == `SMPR_COH_SID);

   // Several coherence writes may be in flight; issue and completion in
   // one cycle cancel, so the wait never drops early
   always @*
   begin
      nxt_coh_cnt = coh_cnt_ff;
      if (coh_issue && !coh_done)
      begin
         nxt_coh_cnt = coh_cnt_ff + 1'b1; // R9
      end
      else if (coh_done && !coh_issue && (|coh_cnt_ff))
      begin
         nxt_coh_cnt = coh_cnt_ff - 1'b1; // R9
      end
   end

   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_ff <= ST_IDLE;
         map_ff <= `SMPR_MAP_RST; // R3
         rsp_valid_ff <= 1'b0;
         rsp_write_ff <= 1'b0;
         rsp_sid_ff <= {SID_W{1'b0}};
         rsp_from_ddr_ff <= 1'b0;
         decode_err_ff <= 1'b0;
         coh_wait_ff <= 1'b0;
         coh_cnt_ff <= {COH_CNT_W{1'b0}};
      end
      else
      begin
         state_ff <= nxt_state;
         map_ff <= ext_sram_map; // R4
         decode_err_ff <= req_valid & ~hit_direct & ~hit_ext;
         if (take_sram)
         begin
            rsp_valid_ff <= 1'b1;
            rsp_write_ff <= sram_rsp_write; // R6
            rsp_sid_ff <= sram_rsp_sid; // R11
            rsp_from_ddr_ff <= 1'b0;
         end
         else if (take_ddr)
         begin
            rsp_valid_ff <= 1'b1;
            rsp_write_ff <= ddr_q_write; // R6
            rsp_sid_ff <= ddr_q_sid; // R11
            rsp_from_ddr_ff <= 1'b1;
         end
         else if (rsp_ready)
         begin
            rsp_valid_ff <= 1'b0;
         end
         coh_cnt_ff <= nxt_coh_cnt;
         // Coherence writer stalls until its last write completes
         coh_wait_ff <= (nxt_coh_cnt != {COH_CNT_W{1'b0}}); // R9
      end
   end
endmodule

// ==== bench/smpr_router_chk.sv ====
`timescale 1ns/1ps
module smpr_router_chk (
   input wire clock,
   input wire rst_n,
   input wire req_valid,
   input wire req_ready,
   input wire [31:0] req_addr,
   input wire req_write,
   input wire [7:0] req_sid,
   input wire [15:0] ext_sram_map,
   input wire sram_req_valid,
   input wire ddr_req_valid,
   input wire sram_rsp_valid,
   input wire sram_rsp_ready,
   input wire ddr_rsp_valid,
   input wire ddr_rsp_ready,
   input wire rsp_valid_ff,
   input wire rsp_ready,
   input wire [7:0] rsp_sid_ff,
   input wire rsp_from_ddr_ff,
   input wire decode_err_ff,
   input wire coh_wait_ff
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire d = req_valid && req_addr[31:24] == 8'h0c;
   wire e = req_valid && req_addr[31];
   wire h = ext_sram_map[req_addr[30:27]];
   sequence ddr_in; ddr_rsp_valid && ddr_rsp_ready; endsequence
   sequence ddr_out; rsp_valid_ff && rsp_from_ddr_ff; endsequence
   a_dir_route: assert property (d |-> sram_req_valid)
      else $error("direct route");
   a_ext_ddr: assert property (e && !h && $stable(ext_sram_map)
      && $past(rst_n) |-> ddr_req_valid && !sram_req_valid) else $error("ddr");
   a_ext_sram: assert property (e && h && $stable(ext_sram_map)
      && $past(rst_n) |-> sram_req_valid && !ddr_req_valid) else $error("sram");
   a_bad_decode: assert property (req_ready && !d && !e && req_valid
      |=> decode_err_ff) else $error("decode");
   a_rsp_hold: assert property (rsp_valid_ff && !rsp_ready |=> rsp_valid_ff
      && $stable(rsp_sid_ff) && $stable(rsp_from_ddr_ff)) else $error("hold");
   a_sram_first: assert property (sram_rsp_valid && sram_rsp_ready
      |=> rsp_valid_ff && !rsp_from_ddr_ff) else $error("priority");
   a_ddr_kept: assert property (ddr_in |-> ##[2:600] ddr_out)
      else $error("ddr lost");
   a_coh_wait: assert property ((d || e) && req_ready && req_write
      && req_sid == 8'h52 |=> coh_wait_ff) else $error("coh wait");
endmodule
bind smpr_router smpr_router_chk i_chk (.*);

// ==== bench/smpr_mem.sv ====
`timescale 1ns/1ps
module smpr_mem (
   input wire clock,
   input wire q_v,
   output reg q_r = 0,
   input wire [9:0] q_d,
   output reg p_v = 0,
   input wire p_r,
   output reg [9:0] p_d = 0
);
   logic [9:0] q[$];
   bit t;
   // Answers in order at random pace; idle lines flip each cycle
   always @(posedge clock)
   begin
      t = p_v && p_r;
      if (t)
         void'(q.pop_front());
      if (q_v && q_r)
         q.push_back(q_d);
      #1 q_r = $urandom_range(3) > 0;
      if (t || !p_v)
      begin
         p_v = q.size() > 0 && $urandom_range(1);
         p_d = p_v ? q[0] : ~p_d;
      end
   end
endmodule

// ==== bench/smpr_router_tb_top.sv ====
`timescale 1ns/1ps
module smpr_router_tb_top;
   reg clock = 0, rst_n = 0, req_valid = 0, req_write = 0, rsp_ready = 0;
   reg [31:0] req_addr = 0;
   reg [7:0] req_sid = 0;
   reg [15:0] ext_sram_map = 0;
   wire req_ready, sram_req_valid, sram_req_ready, sram_req_write, nc;
   wire sram_req_ext, sram_rsp_valid, sram_rsp_ready, sram_rsp_write;
   wire sram_rsp_ext, ddr_req_valid, ddr_req_ready, ddr_req_write;
   wire ddr_rsp_valid, ddr_rsp_ready, ddr_rsp_write, rsp_valid_ff;
   wire rsp_write_ff, rsp_from_ddr_ff, decode_err_ff, coh_wait_ff;
   wire [7:0] sram_req_sid, sram_rsp_sid, ddr_req_sid, ddr_rsp_sid, rsp_sid_ff;
   wire [31:0] sram_req_addr, ddr_req_addr;
   int fail_count = 0, n_compared = 0, pct = 0;
   logic [9:0] sb[$];
   logic [15:0] maps[3] = '{16'h0000, 16'hffff, 16'ha5c3};
   always #12.5 clock = ~clock;
   smpr_router i_smpr_router (.*);
   smpr_mem i_sram (.clock, .q_v(sram_req_valid), .q_r(sram_req_ready),
      .q_d({sram_req_ext, sram_req_write, sram_req_sid}), .p_r(sram_rsp_ready),
      .p_v(sram_rsp_valid), .p_d({sram_rsp_ext, sram_rsp_write, sram_rsp_sid}));
   smpr_mem i_ddr (.clock, .q_v(ddr_req_valid), .q_r(ddr_req_ready),
      .q_d({1'b0, ddr_req_write, ddr_req_sid}), .p_r(ddr_rsp_ready),
      .p_v(ddr_rsp_valid), .p_d({nc, ddr_rsp_write, ddr_rsp_sid}));
   task check(input logic [9:0] g, e);
      n_compared++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task check_addr(input logic [31:0] g, e);
      n_compared++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task complete_run;
      $display("%0d compared, %0d failed", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Expected entry: {from ddr, write, source}
   task send;
      int k;
      k = $urandom_range(2);
      req_addr = $urandom;
      req_addr[31] = k == 1;
      if (k == 0)
         req_addr[31:24] = 8'h0c;
      req_write = $urandom;
      req_sid = $urandom_range(3) ? $urandom : 8'h52;
      if (k == 2)
         req_sid[6] = 0;
      req_valid = 1;
      do @(negedge clock); while (!req_ready);
      if (req_addr[31:24] == 8'h0c)
         sb.push_back({1'b0, req_write, req_sid});
      else if (req_addr[31])
         sb.push_back({!ext_sram_map[req_addr[30:27]], req_write, req_sid});
      if (req_addr[31:24] == 8'h0c)
         check_addr(sram_req_addr, req_addr);
      else if (req_addr[31] && ext_sram_map[req_addr[30:27]])
         check_addr(sram_req_addr, {8'h0c, req_addr[23:0]});
      else if (req_addr[31])
         check_addr(ddr_req_addr, req_addr);
      @(posedge clock);
      #1;
   endtask
   task take(input logic [9:0] g);
      int i[$];
      i = sb.find_first_index(x) with (x === g);
      check(g, i.size() ? sb[i[0]] : ~g);
      if (i.size())
         sb.delete(i[0]);
   endtask
   always @(posedge clock) #1 rsp_ready = $urandom_range(99) < pct;
   always @(negedge clock)
      if (rst_n && rsp_valid_ff && rsp_ready)
         take({rsp_from_ddr_ff, rsp_write_ff, rsp_sid_ff});
   initial
   begin
      void'($urandom(32'h4d9b));
      repeat (3) @(posedge clock);
      #1 rst_n = 1;
      foreach (maps[t])
      begin
         ext_sram_map = maps[t];
         pct = 90 - 30 * t;
         @(posedge clock);
         #1;
         repeat (200) send();
         req_valid = 0;
         for (int n = 0; n < 2000 && sb.size(); n++) @(posedge clock);
         repeat (3) @(posedge clock);
         #1;
         check(sb.size(), 0);
         check(coh_wait_ff, 0);
         $display("map %h done, %0d compared", maps[t], n_compared);
      end
      complete_run;
   end
   initial
   begin
      #1_000_000;
      fail_count++;
      complete_run;
   end
endmodule
